// ==== led_pkg.sv ====
// constants shared by the status lamp driver: map, fields, timing
package led_pkg;

	// =====================================================================
	// register map
	localparam int unsigned   ADR_W       = 8;
	localparam logic [7:0]    CFG_ADDR    = 8'h90;
	localparam logic [31:0]   CFG_RESET   = 32'h0000040E;
	localparam logic [31:0]   CFG_WMASK   = 32'h0001FF7E;
	localparam logic [31:0]   UNMAPPED_RD = 32'h00000000;

	// =====================================================================
	// field positions of the configuration word
	localparam int unsigned   EN_BIT      = 1;
	localparam int unsigned   INV_BIT     = 2;
	localparam int unsigned   STR_BIT     = 3;
	localparam int unsigned   TEN_BIT     = 4;
	localparam int unsigned   HUN_BIT     = 5;
	localparam int unsigned   GIG_BIT     = 6;
	localparam int unsigned   RSV_LO_BIT  = 0;
	localparam int unsigned   RSV_MID_BIT = 7;
	localparam int unsigned   FDX_BIT     = 8;
	localparam int unsigned   ANEG_BIT    = 9;
	localparam int unsigned   LINK_BIT    = 10;
	localparam int unsigned   ADDR_BIT    = 11;
	localparam int unsigned   TX_BIT      = 12;
	localparam int unsigned   RX_BIT      = 13;
	localparam int unsigned   BABBLE_BIT  = 14;
	localparam int unsigned   OVERLAP_BIT = 15;
	localparam int unsigned   CARRIER_BIT = 16;
	localparam int unsigned   MIRROR_BIT  = 31;
	localparam int unsigned   COND_LO     = 4;
	localparam int unsigned   COND_HI     = 16;

	// =====================================================================
	// timing: half periods of the blink rates and the stretch interval
	localparam int unsigned   CLK_KHZ     = 250000;
	localparam int unsigned   TEN_HALF_MS = 500;
	localparam int unsigned   HUN_HALF_MS = 125;
	localparam int unsigned   STRETCH_MS  = 50;
	localparam int unsigned   TEN_HALF_CYC = TEN_HALF_MS * CLK_KHZ;
	localparam int unsigned   HUN_HALF_CYC = HUN_HALF_MS * CLK_KHZ;
	localparam int unsigned   STRETCH_CYC  = STRETCH_MS * CLK_KHZ;

endpackage

// ==== status_led_driver.sv ====
// status lamp driver: config register, blink, stretch, invert, gate
// Summary of operation
// - enable bit, reset one, clearing it forces lamp off, keeps other fields
// - whole configuration loadable from EEPROM at initialisation
// - bit 2, reset one, inverts the combined signal
// - bit 3, reset one, stretches each on or off interval
// - bit 4 with 10 Mb condition blinks the lamp at 1 Hz
// - bit 5 with 100 Mb condition blinks the lamp at 4 Hz
// - bit 6, reset zero, selects 1000 Mb operation
// - bit 8, reset zero, selects full duplex enabled
// - bit 9, reset zero, selects auto-negotiation in progress
// - bit 10, reset one, selects link functional
// - bit 11, reset zero, selects own address match
// - bits 0 and 7 reserved, read zero
// - bits 12 and 13 select transmit and receive in progress
// - bit 14 selects jabbering station detected
// - bit 15 selects simultaneous transmit and receive
// - final lamp signal mirrored into read-only bit 31
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module status_led_driver #(
	parameter int unsigned TEN_HALF_CYCLES = led_pkg::TEN_HALF_CYC,
	parameter int unsigned HUN_HALF_CYCLES = led_pkg::HUN_HALF_CYC,
	parameter int unsigned STRETCH_CYCLES  = led_pkg::STRETCH_CYC
) (
	// clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	// wishbone slave
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [led_pkg::ADR_W-1:0]     wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic      [31:0]                   wb_dat_o,
	output logic                               wb_ack_o,
	// configuration load from eeprom
	input  wire logic                          eeprom_cfg_valid_i,
	input  wire logic [31:0]                   eeprom_cfg_i,
	// latched network conditions, aligned to select bits
	input  wire logic [led_pkg::COND_HI:led_pkg::COND_LO] cond_i,
	// lamp
	output logic                               led_o
);
	import led_pkg::*;

	localparam int unsigned CW = COND_HI - COND_LO + 1;

	logic [31:0]   cfg;
	logic          req;
	logic          hit;
	logic [31:0]   rd_word;
	logic [31:0]   slow_cnt;
	logic [31:0]   fast_cnt;
	logic          blink_slow;
	logic          blink_fast;
	logic [CW-1:0] level_sel;
	logic          next_raw;
	logic          stretched;
	logic [31:0]   hold_cnt;

	// merge bus write data into a word under byte enables and write mask
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] wdat, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = wdat[8*i +: 8];
			end
		end
		return (res & CFG_WMASK) | (old & ~CFG_WMASK);
	endfunction

	// =====================================================================
	// bus decode
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign hit = (wb_adr_i == CFG_ADDR);
	// mirror bit shows what the pin really drives
	assign rd_word = (cfg & CFG_WMASK) | ({31'h00000000, led_o} << MIRROR_BIT);

	// one wait-free answer: ack the cycle after the request is seen
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// read data only during the ack cycle; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (req && !wb_we_i && hit) begin
			wb_dat_o <= rd_word;
		end else begin
			wb_dat_o <= UNMAPPED_RD;
		end
	end

	// =====================================================================
	// configuration register
	// a bus write beats an eeprom load in the same cycle so software wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg <= CFG_RESET;
		end else if (req && wb_we_i && hit) begin
			cfg <= merge(cfg, wb_dat_i, wb_sel_i);
		end else if (eeprom_cfg_valid_i) begin
			cfg <= eeprom_cfg_i & CFG_WMASK;
		end
	end

	// =====================================================================
	// blink generators: free-running half-period counters
	// both run always so a select change blinks without a restart delay
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slow_cnt   <= 32'h00000000;
			blink_slow <= 1'b0;
		end else if (slow_cnt == 32'(TEN_HALF_CYCLES - 1)) begin
			slow_cnt   <= 32'h00000000;
			blink_slow <= !blink_slow;
		end else begin
			slow_cnt <= slow_cnt + 32'h00000001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fast_cnt   <= 32'h00000000;
			blink_fast <= 1'b0;
		end else if (fast_cnt == 32'(HUN_HALF_CYCLES - 1)) begin
			fast_cnt   <= 32'h00000000;
			blink_fast <= !blink_fast;
		end else begin
			fast_cnt <= fast_cnt + 32'h00000001;
		end
	end

	// =====================================================================
	// combine selected conditions; 10 Mb and 100 Mb selections blink instead
	always_comb begin
		level_sel = cfg[COND_HI:COND_LO] & cond_i;
		next_raw  = (level_sel[TEN_BIT-COND_LO] & blink_slow)
			| (level_sel[HUN_BIT-COND_LO] & blink_fast)
			| (|level_sel[CW-1:GIG_BIT-COND_LO]);
	end

	// =====================================================================
	// pulse stretcher: a level, once taken, stands for the hold interval
	// short events stay visible at the cost of lagging real changes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stretched <= 1'b0;
			hold_cnt  <= 32'h00000000;
		end else if (!cfg[STR_BIT]) begin
			stretched <= next_raw;
			hold_cnt  <= 32'h00000000;
		end else if (hold_cnt != 32'h00000000) begin
			hold_cnt <= hold_cnt - 32'h00000001;
		end else if (next_raw != stretched) begin
			stretched <= next_raw;
			hold_cnt  <= 32'(STRETCH_CYCLES - 1);
		end
	end

	// =====================================================================
	// output: invert then gate, enable clear forces the lamp off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			led_o <= 1'b0;
		end else begin
			led_o <= cfg[EN_BIT] & (stretched ^ cfg[INV_BIT]);
		end
	end

	// =====================================================================
	// assertions
	property p_enable_gate;
		@(posedge clk_i) disable iff (rst_i)
		!cfg[EN_BIT] |=> !led_o;
	endproperty
	a_enable_gate: assert property (p_enable_gate)
		else $error("lamp lit while enable clear");

	property p_enable_keeps;
		@(posedge clk_i) disable iff (rst_i)
		(req && wb_we_i && hit && wb_sel_i[0] && !wb_dat_i[EN_BIT])
		|=> (cfg[31:8] == $past(cfg[31:8]) || $past(wb_sel_i[3:1]) != 3'h0);
	endproperty
	a_enable_keeps: assert property (p_enable_keeps)
		else $error("clearing enable disturbed other fields");

	property p_eeprom_load;
		@(posedge clk_i) disable iff (rst_i)
		(eeprom_cfg_valid_i && !(req && wb_we_i && hit))
		|=> cfg == ($past(eeprom_cfg_i) & CFG_WMASK);
	endproperty
	a_eeprom_load: assert property (p_eeprom_load)
		else $error("eeprom load not taken");

	property p_polarity;
		@(posedge clk_i) disable iff (rst_i)
		cfg[EN_BIT] |=> led_o == ($past(stretched) ^ $past(cfg[INV_BIT]));
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("lamp polarity wrong");

	property p_stretch_hold;
		@(posedge clk_i) disable iff (rst_i)
		(cfg[STR_BIT] && hold_cnt != 32'h00000000)
		|=> $stable(stretched);
	endproperty
	a_stretch_hold: assert property (p_stretch_hold)
		else $error("stretched level changed inside hold interval");

	property p_stretch_load;
		@(posedge clk_i) disable iff (rst_i)
		($changed(stretched) && $past(cfg[STR_BIT]))
		|-> hold_cnt == 32'(STRETCH_CYCLES - 1);
	endproperty
	a_stretch_load: assert property (p_stretch_load)
		else $error("hold interval not started on change");

	property p_slow_blink;
		@(posedge clk_i) disable iff (rst_i)
		$changed(blink_slow) |-> $past(slow_cnt) == 32'(TEN_HALF_CYCLES - 1);
	endproperty
	a_slow_blink: assert property (p_slow_blink)
		else $error("slow blink toggled off period");

	property p_fast_blink;
		@(posedge clk_i) disable iff (rst_i)
		$changed(blink_fast) |-> $past(fast_cnt) == 32'(HUN_HALF_CYCLES - 1);
	endproperty
	a_fast_blink: assert property (p_fast_blink)
		else $error("fast blink toggled off period");

	property p_reserved;
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |-> !cfg[RSV_LO_BIT] && !cfg[RSV_MID_BIT] && !rd_word[RSV_LO_BIT];
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bit set");

	property p_mirror;
		@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && hit) |=> wb_dat_o[MIRROR_BIT] == $past(led_o);
	endproperty
	a_mirror: assert property (p_mirror)
		else $error("mirror bit differs from lamp");

	property p_direct_path;
		@(posedge clk_i) disable iff (rst_i)
		!cfg[STR_BIT] |=> stretched == $past(next_raw);
	endproperty
	a_direct_path: assert property (p_direct_path)
		else $error("unstretched path lost the combined level");

	property p_link_select;
		@(posedge clk_i) disable iff (rst_i)
		(cfg[LINK_BIT] && cond_i[LINK_BIT]) |-> next_raw;
	endproperty
	a_link_select: assert property (p_link_select)
		else $error("link condition not shown");

	// bus handshake: one ack per request, data only while ack stands
	property p_ack_answer;
		@(posedge clk_i) disable iff (rst_i)
		req |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer)
		else $error("request not acknowledged next cycle");

	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack held longer than one cycle");

	property p_idle_zero;
		@(posedge clk_i) disable iff (rst_i)
		!wb_ack_o |-> wb_dat_o == 32'h00000000;
	endproperty
	a_idle_zero: assert property (p_idle_zero)
		else $error("read data driven outside ack");

	property p_unmapped_read;
		@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && !hit)
		|=> wb_dat_o == UNMAPPED_RD;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped read returned data");

	property p_unmapped_write;
		@(posedge clk_i) disable iff (rst_i)
		(req && wb_we_i && !hit && !eeprom_cfg_valid_i)
		|=> $stable(cfg);
	endproperty
	a_unmapped_write: assert property (p_unmapped_write)
		else $error("unmapped write changed configuration");

	// unused high field stays clear whatever bus or eeprom deliver
	property p_upper_zero;
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |-> cfg[MIRROR_BIT-1:CARRIER_BIT+1] == '0;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("unused high field set");

	// lamp path: a selected, present condition must reach the combiner
	property p_ten_show;
		@(posedge clk_i) disable iff (rst_i)
		(cfg[TEN_BIT] && cond_i[TEN_BIT] && blink_slow)
		|-> next_raw;
	endproperty
	a_ten_show: assert property (p_ten_show)
		else $error("slow blink not shown");

	property p_any_sel;
		@(posedge clk_i) disable iff (rst_i)
		(|(cfg[CARRIER_BIT:GIG_BIT] & cond_i[CARRIER_BIT:GIG_BIT]))
		|-> next_raw;
	endproperty
	a_any_sel: assert property (p_any_sel)
		else $error("selected level condition not shown");

	property p_dark;
		@(posedge clk_i) disable iff (rst_i)
		((cfg[COND_HI:COND_LO] & cond_i) == '0) |-> !next_raw;
	endproperty
	a_dark: assert property (p_dark)
		else $error("combined level high with nothing selected");

	c_lamp_on: cover property (@(posedge clk_i) disable iff (rst_i)
		$rose(led_o));
	c_disable: cover property (@(posedge clk_i) disable iff (rst_i)
		$fell(cfg[EN_BIT]));
	c_load: cover property (@(posedge clk_i) disable iff (rst_i)
		eeprom_cfg_valid_i);
	c_read: cover property (@(posedge clk_i) disable iff (rst_i)
		req && !wb_we_i && hit);

endmodule

// ==== led_lamp.sv ====
// behavioural indicator lamp that times how long each level lasted
`timescale 1ns/1ps

module led_lamp (
	// clock and lamp drive
	input  wire logic  clk_i,
	input  wire logic  led_i,
	// length in cycles of the last completed level
	output int unsigned width_o
);
	// =====================================================================
	// level timer
	int unsigned run;
	logic        prev;

	initial begin
		run = 0;
		prev = 1'b0;
		width_o = 0;
	end

	// a person only sees levels, so the lamp reports widths, not edges
	always @(posedge clk_i) begin
		if (led_i !== prev) begin
			width_o <= run;
			run <= 1;
		end else begin
			run <= run + 1;
		end
		prev <= led_i;
	end
endmodule

// ==== status_led_driver_test.sv ====
// self-checking bench for the status lamp driver
`timescale 1ns/1ps

module status_led_driver_test;
	import led_pkg::*;

	// =====================================================================
	// shortened counts keep the run brief
	localparam int unsigned TEN   = 40;
	localparam int unsigned HUN   = 10;
	localparam int unsigned STR   = 8;
	localparam int unsigned LIMIT = 5000;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'hF;
	logic [31:0] dat = 32'h0;
	logic        eep_v = 1'b0;
	logic [31:0] eep = 32'h0;
	logic [16:4] cond = '0;
	logic [16:4] c;
	logic [31:0] rdat;
	logic [31:0] rd;
	logic        ack;
	logic        led;
	int unsigned width;
	int unsigned b;
	int unsigned sels[11] = '{6, 8, 9, 10, 11, 12, 13, 14, 15, 16, 16};
	int          n_errors = 0;
	int          check_count = 0;
	int          cycles = 0;

	always #2 clk = ~clk;

	status_led_driver #(
		.TEN_HALF_CYCLES (TEN),
		.HUN_HALF_CYCLES (HUN),
		.STRETCH_CYCLES  (STR)
	) i_dut (
		.clk_i              (clk),
		.rst_i              (rst),
		.wb_cyc_i           (cyc),
		.wb_stb_i           (stb),
		.wb_we_i            (we),
		.wb_adr_i           (adr),
		.wb_sel_i           (sel),
		.wb_dat_i           (dat),
		.wb_dat_o           (rdat),
		.wb_ack_o           (ack),
		.eeprom_cfg_valid_i (eep_v),
		.eeprom_cfg_i       (eep),
		.cond_i             (cond),
		.led_o              (led)
	);

	led_lamp i_lamp (
		.clk_i   (clk),
		.led_i   (led),
		.width_o (width)
	);

	// =====================================================================
	// tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	// classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
			input logic [31:0] d, input logic [3:0] s,
			output logic [31:0] r);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// hang guard: the whole sequence needs well under two thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_errors++;
			end_sim();
		end
	end

	// =====================================================================
	// main sequence
	initial begin
		tick(12);
		rst <= 1'b0;
		tick(4);
		wb(1'b0, CFG_ADDR, 32'h0, 4'hF, rd);
		chk(32'h8000040E, rd);
		$display("test reset values done");
		wb(1'b1, CFG_ADDR, 32'hFFFFFFFD, 4'hF, rd);
		tick(3);
		wb(1'b0, CFG_ADDR, 32'h0, 4'hF, rd);
		chk(32'h0001FF7C, rd);
		wb(1'b1, CFG_ADDR, 32'h0, 4'h1, rd);
		wb(1'b0, CFG_ADDR, 32'h0, 4'hF, rd);
		chk(32'h0001FF00, rd);
		wb(1'b1, 8'h94, 32'hFFFFFFFF, 4'hF, rd);
		wb(1'b0, 8'h94, 32'h0, 4'hF, rd);
		chk(32'h0, rd);
		wb(1'b0, CFG_ADDR, 32'h0, 4'hF, rd);
		chk(32'h0001FF00, rd);
		$display("test register access done");
		// each level select passes its own condition and ignores all others
		for (int i = 0; i < 11; i++) begin
			b = sels[i];
			c = '0;
			c[b] = 1'b1;
			wb(1'b1, CFG_ADDR, 32'h2 | (32'h1 << b), 4'hF, rd);
			cond <= c;
			tick(4);
			chk(32'h1, 32'(led));
			cond <= ~c;
			tick(4);
			chk(32'h0, 32'(led));
		end
		$display("test condition selects done");
		cond <= '0;
		wb(1'b1, CFG_ADDR, 32'h6, 4'hF, rd);
		tick(3);
		chk(32'h1, 32'(led));
		wb(1'b1, CFG_ADDR, 32'h4, 4'hF, rd);
		tick(3);
		chk(32'h0, 32'(led));
		wb(1'b0, CFG_ADDR, 32'h0, 4'hF, rd);
		chk(32'h4, rd);
		// software finds the lamp dark and sets only the enable bit
		wb(1'b1, CFG_ADDR, rd | 32'h2, 4'h1, rd);
		wb(1'b0, CFG_ADDR, 32'h0, 4'hF, rd);
		chk(32'h80000006, rd);
		chk(32'h1, 32'(led));
		$display("test invert and enable done");
		cond <= '1;
		wb(1'b1, CFG_ADDR, 32'h12, 4'hF, rd);
		tick(3 * TEN + 10);
		chk(TEN, width);
		wb(1'b1, CFG_ADDR, 32'h22, 4'hF, rd);
		tick(4 * HUN + 10);
		chk(HUN, width);
		$display("test blink rates done");
		cond <= '0;
		wb(1'b1, CFG_ADDR, 32'h40A, 4'hF, rd);
		tick(20);
		cond <= 13'h040;
		@(posedge clk);
		cond <= '0;
		tick(STR + 10);
		chk(32'h1, 32'(width >= STR && width <= STR + 1));
		$display("test stretch done");
		eep_v <= 1'b1;
		eep <= 32'hFFFFFFFF;
		@(posedge clk);
		eep_v <= 1'b0;
		tick(STR + 6);
		wb(1'b0, CFG_ADDR, 32'h0, 4'hF, rd);
		chk(32'h8001FF7E, rd);
		$display("test eeprom load done");
		end_sim();
	end
endmodule
